/* File: rtl/fpr_pkg.sv */
package fpr_pkg;
  localparam int CLK_MHZ = 250;
  // Delay figures; longest times, so cycle counts round down
  localparam int RELEASE_DELAY_NS = 3000;
  localparam int SIG_RELEASE_DELAY_NS = 1800;
  localparam int RECOVERY_OTHER_NS = 12000;
  localparam int RECOVERY_PROG_NS = 40000;
  localparam int RELEASE_CYC = RELEASE_DELAY_NS * CLK_MHZ / 1000;
  localparam int SIG_RELEASE_CYC = SIG_RELEASE_DELAY_NS * CLK_MHZ / 1000;
  localparam int RECOVERY_OTHER_CYC = RECOVERY_OTHER_NS * CLK_MHZ / 1000;
  localparam int RECOVERY_PROG_CYC = RECOVERY_PROG_NS * CLK_MHZ / 1000;
  localparam int DELAY_W = 16;

  localparam logic [7:0] OPC_RELEASE = 8'hc1;
  localparam logic [7:0] OPC_SIG_READ = 8'hc2;
  localparam logic [7:0] OPC_RESET_ARM = 8'hc3;
  localparam logic [7:0] OPC_RESET = 8'hc4;
  localparam logic [7:0] OPC_FACTORY = 8'hc5;
  localparam logic [7:0] OPC_WRITE_UNLOCK = 8'hc6;
  localparam logic [7:0] OPC_DEEP_SLEEP = 8'hc7;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'hc8;
  localparam logic [7:0] OPC_HALF_BLOCK_ERASE = 8'hc9;
  localparam logic [7:0] OPC_BLOCK_ERASE = 8'hca;
  localparam logic [7:0] OPC_CHIP_ERASE = 8'hcb;
  localparam logic [7:0] OPC_PTBL_READ = 8'h5a;

  // Signature value is arbitrary
  localparam logic [7:0] SIGNATURE = 8'h3c;
  localparam int PTBL_LEN = 8;
  localparam int PTBL_AW = 3;
  // Table contents are arbitrary
  localparam logic [7:0] PTBL [PTBL_LEN] = '{8'h11, 8'h22, 8'h33, 8'h44,
    8'h55, 8'h66, 8'h77, 8'h88};
  localparam logic [7:0] PTBL_PAD = 8'hff;
  localparam logic [2:0] ADDR_LAST = 3'h3;
  localparam logic [2:0] SIG_MIN_BYTES = 3'h5;
  localparam logic [2:0] ERASE_ADDR_BYTES = 3'h4;
  localparam int FIFO_DEPTH = 4;

  localparam logic [1:0] ERS_SECTOR = 2'h0;
  localparam logic [1:0] ERS_HALF_BLOCK = 2'h1;
  localparam logic [1:0] ERS_BLOCK = 2'h2;
  localparam logic [1:0] ERS_CHIP = 2'h3;

  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_SUP = 3;
  localparam int PIN_N = 4;
  localparam logic [PIN_N-1:0] PIN_RST = 4'h1;

  typedef enum logic [2:0] {FR_OPC, FR_ADDR, FR_DUMMY, FR_SIG, FR_PTBL,
    FR_IGN} fpr_frame_t;
  typedef enum logic [1:0] {PW_STBY, PW_DEEP, PW_WAKE, PW_RECOV} fpr_pwr_t;
endpackage : fpr_pkg

/* File: rtl/fpr_fifo_if.sv */
`timescale 1ns/100ps
interface fpr_fifo_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic flush;
  modport prod (output in_valid, in_data, out_ready, flush,
    input in_ready, out_valid, out_data);
  modport fifo (input in_valid, in_data, out_ready, flush,
    output in_ready, out_valid, out_data);
endinterface : fpr_fifo_if

/* File: rtl/fpr_fifo.sv */
`timescale 1ns/100ps
module fpr_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  fpr_fifo_if.fifo f
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign f.in_ready = (cnt_r != (AW+1)'(D)) && !f.flush;
  assign f.out_valid = (cnt_r != '0);
  assign f.out_data = mem_r[rp_r];

  always_comb begin
    push = f.in_valid && f.in_ready;
    pop = f.out_valid && f.out_ready;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (f.flush) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        wp_nxt = (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_nxt = (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push && !f.flush) begin
      mem_r[wp_r] <= f.in_data;
    end
  end
endmodule : fpr_fifo

/* File: rtl/fpr_cmd_core.sv */
`timescale 1ns/100ps
module fpr_cmd_core
  import fpr_pkg::*;
#(
  parameter logic [7:0] RELEASE_OPC = OPC_RELEASE,
  parameter logic [7:0] SIG_OPC = OPC_SIG_READ,
  parameter logic [7:0] ARM_OPC = OPC_RESET_ARM,
  parameter logic [7:0] RESET_OPC = OPC_RESET,
  parameter logic [7:0] FACTORY_OPC = OPC_FACTORY,
  parameter int REL_CYC = RELEASE_CYC,
  parameter int SREL_CYC = SIG_RELEASE_CYC,
  parameter int RCV_OTH_CYC = RECOVERY_OTHER_CYC,
  parameter int RCV_PRG_CYC = RECOVERY_PROG_CYC,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic supply_ok,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic array_busy,
  input wire logic array_prog,
  output logic so,
  output logic so_oe,
  output logic standby,
  output logic deep_sleep,
  output logic delay_run,
  output logic write_unlock_latch,
  output logic factory_accel,
  output logic erase_start,
  output logic [1:0] erase_kind,
  output logic [23:0] erase_addr,
  output logic op_abort
);
  logic [PIN_N-1:0] ff1_r, ff2_r, ff3_r, st_r, st_nxt;
  logic rst_n_int, cs_rise, sck_rise, sck_fall, acc, erase_ok, recov_prog;
  logic [7:0] rx;
  logic [2:0] ers;
  fpr_frame_t fst_r, fst_nxt;
  fpr_pwr_t pwr_r, pwr_nxt;
  logic [2:0] bcnt_r, bcnt_nxt, bytes_r, bytes_nxt;
  logic [7:0] sh_r, sh_nxt, opc_r, opc_nxt, obyte_r, obyte_nxt;
  logic [23:0] addr_r, addr_nxt, paddr_r, paddr_nxt;
  logic [DELAY_W-1:0] dcnt_r, dcnt_nxt;
  logic acc_r, acc_nxt, arm_r, arm_nxt, busy_d_r, last_prog_r, last_prog_nxt;
  logic ers_pend_r, ers_pend_nxt, ers_fast_r, ers_fast_nxt;
  logic so_r, so_nxt, so_oe_r, so_oe_nxt, wul_r, wul_nxt, fac_r, fac_nxt;
  logic es_r, es_nxt, abort_r, abort_nxt, pop;
  logic [1:0] ekind_r, ekind_nxt;
  logic [23:0] eaddr_r, eaddr_nxt;
  logic stby_r, deep_r, drun_r;

  fpr_fifo_if #(.W(8)) fq ();

  fpr_fifo #(.W(8), .D(FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .resetn(rst_n_int),
    .f(fq.fifo)
  );

  function automatic logic [2:0] ers_code(input logic [7:0] o);
    ers_code = 3'h0;
    if (o == OPC_SECTOR_ERASE) ers_code = {1'b1, ERS_SECTOR};
    if (o == OPC_HALF_BLOCK_ERASE) ers_code = {1'b1, ERS_HALF_BLOCK};
    if (o == OPC_BLOCK_ERASE) ers_code = {1'b1, ERS_BLOCK};
    if (o == OPC_CHIP_ERASE) ers_code = {1'b1, ERS_CHIP};
  endfunction : ers_code

  // A pin change counts once the second and third stages agree
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      st_nxt[i] = (ff2_r[i] == ff3_r[i]) ? ff3_r[i] : st_r[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ff1_r <= PIN_RST;
      ff2_r <= PIN_RST;
      ff3_r <= PIN_RST;
      st_r <= PIN_RST;
    end else begin
      ff1_r <= {supply_ok, si, sclk, cs_n};
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      st_r <= st_nxt;
    end
  end

  assign rst_n_int = resetn && st_r[PIN_SUP];
  assign fq.flush = st_r[PIN_CS];
  assign fq.in_valid = !st_r[PIN_CS] && (fst_r == FR_DUMMY || fst_r == FR_PTBL);
  assign fq.in_data = (paddr_r < 24'(PTBL_LEN)) ?
    PTBL[paddr_r[PTBL_AW-1:0]] : PTBL_PAD;
  assign fq.out_ready = pop;

  always_comb begin
    cs_rise = st_nxt[PIN_CS] && !st_r[PIN_CS];
    sck_rise = !st_r[PIN_CS] && st_nxt[PIN_SCLK] && !st_r[PIN_SCLK];
    sck_fall = !st_r[PIN_CS] && !st_nxt[PIN_SCLK] && st_r[PIN_SCLK];
    rx = {sh_r[6:0], st_nxt[PIN_SI]};
    ers = ers_code(opc_r);
    recov_prog = array_busy ? array_prog : last_prog_r;
    fst_nxt = fst_r;
    pwr_nxt = pwr_r;
    bcnt_nxt = bcnt_r;
    bytes_nxt = bytes_r;
    sh_nxt = sh_r;
    opc_nxt = opc_r;
    obyte_nxt = obyte_r;
    addr_nxt = addr_r;
    paddr_nxt = paddr_r;
    dcnt_nxt = dcnt_r;
    acc_nxt = acc_r;
    arm_nxt = arm_r;
    last_prog_nxt = array_busy ? array_prog : last_prog_r;
    ers_pend_nxt = ers_pend_r;
    ers_fast_nxt = ers_fast_r;
    so_nxt = so_r;
    so_oe_nxt = so_oe_r;
    wul_nxt = wul_r;
    fac_nxt = fac_r;
    es_nxt = 1'b0;
    ekind_nxt = ekind_r;
    eaddr_nxt = eaddr_r;
    abort_nxt = 1'b0;
    pop = 1'b0;
    acc = 1'b0;
    erase_ok = 1'b0;
    if (busy_d_r && !array_busy && ers_pend_r) begin
      wul_nxt = 1'b0;
      ers_pend_nxt = 1'b0;
      if (ers_fast_r) begin
        fac_nxt = 1'b0;
      end
    end
    if (pwr_r == PW_WAKE || pwr_r == PW_RECOV) begin
      if (dcnt_r == '0) begin
        pwr_nxt = PW_STBY;
      end else begin
        dcnt_nxt = dcnt_r - 1'b1;
      end
    end
    if (fq.in_valid && fq.in_ready) begin
      paddr_nxt = paddr_r + 24'h1;
    end
    if (st_r[PIN_CS]) begin
      fst_nxt = FR_OPC;
      bcnt_nxt = 3'h0;
      bytes_nxt = 3'h0;
      so_nxt = 1'b0;
      so_oe_nxt = 1'b0;
    end else begin
      if (sck_rise) begin
        bcnt_nxt = bcnt_r + 3'h1;
        sh_nxt = rx;
        if (bcnt_r == 3'h7) begin
          if (bytes_r != 3'h7) begin
            bytes_nxt = bytes_r + 3'h1;
          end
          case (fst_r)
            FR_OPC: begin
              opc_nxt = rx;
              if (pwr_r == PW_WAKE || pwr_r == PW_RECOV) begin
                acc = 1'b0;
              end else if (pwr_r == PW_DEEP) begin
                acc = (rx == RELEASE_OPC || rx == SIG_OPC) && !array_busy;
              end else if (array_busy) begin
                acc = (rx == ARM_OPC || rx == RESET_OPC);
              end else begin
                acc = 1'b1;
              end
              acc_nxt = acc;
              if (acc && (rx == SIG_OPC || rx == OPC_PTBL_READ ||
                  (ers_code(rx) != 3'h0 && rx != OPC_CHIP_ERASE))) begin
                fst_nxt = FR_ADDR;
              end else begin
                fst_nxt = FR_IGN;
              end
            end
            FR_ADDR: begin
              addr_nxt = {addr_r[15:0], rx};
              if (bytes_r == ADDR_LAST) begin
                if (opc_r == SIG_OPC) begin
                  fst_nxt = FR_SIG;
                  obyte_nxt = SIGNATURE;
                end else if (opc_r == OPC_PTBL_READ) begin
                  fst_nxt = FR_DUMMY;
                  paddr_nxt = {addr_r[15:0], rx};
                end else begin
                  fst_nxt = FR_IGN;
                end
              end
            end
            FR_DUMMY, FR_PTBL: begin
              fst_nxt = FR_PTBL;
              pop = fq.out_valid;
              obyte_nxt = fq.out_valid ? fq.out_data : PTBL_PAD;
            end
            FR_SIG: obyte_nxt = SIGNATURE;
            default: ;
          endcase
        end
      end
      if (sck_fall && (fst_r == FR_SIG || fst_r == FR_PTBL)) begin
        so_nxt = obyte_r[3'h7 - bcnt_r];
        so_oe_nxt = 1'b1;
      end
    end
    if (cs_rise && bytes_r != 3'h0) begin
      if (opc_r != ARM_OPC) begin
        arm_nxt = 1'b0;
      end
      if (acc_r && bcnt_r == 3'h0) begin
        if (opc_r == RELEASE_OPC && bytes_r == 3'h1) begin
          if (pwr_r == PW_DEEP) begin
            pwr_nxt = PW_WAKE;
            dcnt_nxt = DELAY_W'(REL_CYC - 1);
          end
        end else if (opc_r == SIG_OPC && bytes_r >= SIG_MIN_BYTES) begin
          if (pwr_r == PW_DEEP) begin
            pwr_nxt = PW_WAKE;
            dcnt_nxt = DELAY_W'(SREL_CYC - 1);
          end
        end else if (opc_r == ARM_OPC && bytes_r == 3'h1) begin
          arm_nxt = 1'b1;
        end else if (opc_r == RESET_OPC && bytes_r == 3'h1 && arm_r) begin
          wul_nxt = 1'b0;
          fac_nxt = 1'b0;
          ers_pend_nxt = 1'b0;
          ers_fast_nxt = 1'b0;
          abort_nxt = array_busy;
          pwr_nxt = PW_RECOV;
          dcnt_nxt = recov_prog ? DELAY_W'(RCV_PRG_CYC - 1) :
            DELAY_W'(RCV_OTH_CYC - 1);
        end else if (opc_r == FACTORY_OPC && bytes_r == 3'h1) begin
          fac_nxt = 1'b1;
        end else if (opc_r == OPC_WRITE_UNLOCK && bytes_r == 3'h1) begin
          wul_nxt = 1'b1;
        end else if (opc_r == OPC_DEEP_SLEEP && bytes_r == 3'h1) begin
          pwr_nxt = PW_DEEP;
        end else if (ers != 3'h0 && wul_r) begin
          erase_ok = (ers[1:0] == ERS_CHIP) ? (bytes_r == 3'h1) :
            (bytes_r == ERASE_ADDR_BYTES);
          if (erase_ok) begin
            es_nxt = 1'b1;
            ekind_nxt = ers[1:0];
            eaddr_nxt = addr_r;
            ers_pend_nxt = 1'b1;
            ers_fast_nxt = fac_r;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n_int) begin
      fst_r <= FR_OPC;
      pwr_r <= PW_STBY;
      bcnt_r <= 3'h0;
      bytes_r <= 3'h0;
      sh_r <= 8'h00;
      opc_r <= 8'h00;
      obyte_r <= 8'h00;
      addr_r <= 24'h0;
      paddr_r <= 24'h0;
      dcnt_r <= '0;
      acc_r <= 1'b0;
      arm_r <= 1'b0;
      busy_d_r <= 1'b0;
      last_prog_r <= 1'b0;
      ers_pend_r <= 1'b0;
      ers_fast_r <= 1'b0;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
      wul_r <= 1'b0;
      fac_r <= 1'b0;
      es_r <= 1'b0;
      ekind_r <= 2'h0;
      eaddr_r <= 24'h0;
      abort_r <= 1'b0;
      stby_r <= 1'b1;
      deep_r <= 1'b0;
      drun_r <= 1'b0;
    end else begin
      fst_r <= fst_nxt;
      pwr_r <= pwr_nxt;
      bcnt_r <= bcnt_nxt;
      bytes_r <= bytes_nxt;
      sh_r <= sh_nxt;
      opc_r <= opc_nxt;
      obyte_r <= obyte_nxt;
      addr_r <= addr_nxt;
      paddr_r <= paddr_nxt;
      dcnt_r <= dcnt_nxt;
      acc_r <= acc_nxt;
      arm_r <= arm_nxt;
      busy_d_r <= array_busy;
      last_prog_r <= last_prog_nxt;
      ers_pend_r <= ers_pend_nxt;
      ers_fast_r <= ers_fast_nxt;
      so_r <= so_nxt;
      so_oe_r <= so_oe_nxt;
      wul_r <= wul_nxt;
      fac_r <= fac_nxt;
      es_r <= es_nxt;
      ekind_r <= ekind_nxt;
      eaddr_r <= eaddr_nxt;
      abort_r <= abort_nxt;
      stby_r <= (pwr_nxt == PW_STBY);
      deep_r <= (pwr_nxt == PW_DEEP);
      drun_r <= (pwr_nxt == PW_WAKE || pwr_nxt == PW_RECOV);
    end
  end

  assign so = so_r;
  assign so_oe = so_oe_r;
  assign standby = stby_r;
  assign deep_sleep = deep_r;
  assign delay_run = drun_r;
  assign write_unlock_latch = wul_r;
  assign factory_accel = fac_r;
  assign erase_start = es_r;
  assign erase_kind = ekind_r;
  assign erase_addr = eaddr_r;
  assign op_abort = abort_r;

  property p_wake_load;
    @(posedge clk_sys) disable iff (!rst_n_int)
    $rose(pwr_r == PW_WAKE) |-> dcnt_r == DELAY_W'(REL_CYC - 1) ||
      dcnt_r == DELAY_W'(SREL_CYC - 1);
  endproperty
  a_wake_load: assert property (p_wake_load) else $error("bad wake load");
  property p_wake_end;
    @(posedge clk_sys) disable iff (!rst_n_int)
    (pwr_r == PW_WAKE && dcnt_r == '0) |=> standby && !delay_run;
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("no standby");
  property p_rel_imm;
    @(posedge clk_sys) disable iff (!rst_n_int)
    (pwr_r == PW_STBY && cs_rise && opc_r == RELEASE_OPC && acc_r) |=>
      standby;
  endproperty
  a_rel_imm: assert property (p_rel_imm) else $error("release delayed");
  property p_sig_repeat;
    @(posedge clk_sys) disable iff (!rst_n_int)
    (fst_r == FR_SIG && sck_rise && bcnt_r == 3'h7) |=> obyte_r == SIGNATURE;
  endproperty
  a_sig_repeat: assert property (p_sig_repeat) else $error("sig lost");
  property p_busy_no_wake;
    @(posedge clk_sys) disable iff (!rst_n_int)
    (pwr_r == PW_DEEP && array_busy) |=> pwr_r != PW_WAKE;
  endproperty
  a_busy_no_wake: assert property (p_busy_no_wake) else $error("woke busy");
  property p_armed;
    @(posedge clk_sys) disable iff (!rst_n_int)
    $rose(pwr_r == PW_RECOV) |-> $past(arm_r) && !arm_r;
  endproperty
  a_armed: assert property (p_armed) else $error("reset not armed");
  property p_reset_clear;
    @(posedge clk_sys) disable iff (!rst_n_int)
    $rose(pwr_r == PW_RECOV) |-> !write_unlock_latch && !factory_accel &&
      op_abort == $past(array_busy);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left");
  property p_recov_len;
    @(posedge clk_sys) disable iff (!rst_n_int)
    $rose(pwr_r == PW_RECOV) |-> dcnt_r == ($past(recov_prog) ?
      DELAY_W'(RCV_PRG_CYC - 1) : DELAY_W'(RCV_OTH_CYC - 1));
  endproperty
  a_recov_len: assert property (p_recov_len) else $error("bad recovery");
  property p_fac_clear;
    @(posedge clk_sys) disable iff (!rst_n_int)
    (ers_pend_r && ers_fast_r && busy_d_r && !array_busy) |=>
      !factory_accel && !write_unlock_latch;
  endproperty
  a_fac_clear: assert property (p_fac_clear) else $error("flag kept");
  property p_supply;
    @(posedge clk_sys) disable iff (!resetn)
    !st_r[PIN_SUP] |=> standby && !so_oe && !write_unlock_latch && !erase_start;
  endproperty
  a_supply: assert property (p_supply) else $error("live in low supply");
  c_wake: cover property (@(posedge clk_sys) $fell(delay_run) && standby);
  c_sig: cover property (@(posedge clk_sys) fst_r == FR_SIG && so_oe);
  c_ptbl: cover property (@(posedge clk_sys) fst_r == FR_PTBL && pop);
  c_fast: cover property (@(posedge clk_sys) erase_start && factory_accel);
endmodule : fpr_cmd_core

/* File: bench/fpr_host.sv */
`timescale 1ns/100ps
module fpr_host (
  input wire logic clk_sys,
  input wire logic so,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  task automatic half();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : half

  // Mode 0; link clock stands low outside frames
  task automatic frame(input int nb, input logic [55:0] d,
      output logic [15:0] rx);
    @(posedge clk_sys);
    #1;
    cs_n = 1'b0;
    for (int i = 0; i < nb * 8; i++) begin
      si = d[55-i];
      half();
      rx = {rx[14:0], so};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    // Released line must not keep its last value
    si = ~si;
  endtask : frame
endmodule : fpr_host

/* File: bench/tb.sv */
`timescale 1ns/100ps
module tb;
  import fpr_pkg::*;
  localparam int REL = 8, SREL = 6, ROTH = 10, RPRG = 20;
  logic clk_sys = 1'b0, resetn = 1'b0, supply_ok = 1'b0;
  logic array_busy = 1'b0, array_prog = 1'b0;
  logic cs_n, sclk, si, so, so_oe, standby, deep_sleep, delay_run;
  logic latch, factory, erase_start, op_abort;
  logic [1:0] erase_kind;
  logic [23:0] erase_addr, ea;
  logic [15:0] rx;
  int mismatches = 0, cmp_count = 0, n_ers = 0, n_abt = 0, n_oe = 0;
  int seed = 53, a, b_ers, b_abt, b_oe;

  always #2 clk_sys = ~clk_sys;

  fpr_host host (.clk_sys(clk_sys), .so(so), .cs_n(cs_n), .sclk(sclk),
    .si(si));

  fpr_cmd_core #(.REL_CYC(REL), .SREL_CYC(SREL), .RCV_OTH_CYC(ROTH),
    .RCV_PRG_CYC(RPRG)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .supply_ok(supply_ok), .cs_n(cs_n), .sclk(sclk), .si(si),
    .array_busy(array_busy), .array_prog(array_prog), .so(so),
    .so_oe(so_oe), .standby(standby), .deep_sleep(deep_sleep),
    .delay_run(delay_run), .write_unlock_latch(latch),
    .factory_accel(factory), .erase_start(erase_start),
    .erase_kind(erase_kind), .erase_addr(erase_addr), .op_abort(op_abort));

  // Counted mid-cycle, clear of the edges that launch the pulses
  always @(negedge clk_sys) begin
    if (erase_start === 1'b1) n_ers++;
    if (op_abort === 1'b1) n_abt++;
    if (so_oe === 1'b1) n_oe++;
  end

  function automatic logic [7:0] tbl_exp(int i);
    return (i < PTBL_LEN) ? PTBL[i] : PTBL_PAD;
  endfunction : tbl_exp

  task automatic results();
    $display("checks %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic send(int nb, logic [55:0] d);
    host.frame(nb, d, rx);
  endtask : send

  task automatic cmd(logic [7:0] opc);
    send(1, {opc, 48'h0});
    tick(10);
  endtask : cmd

  // Select stays high for the whole measured delay
  task automatic dly(string nm, int e);
    int n;
    n = 0;
    for (int i = 0; i < 40 && delay_run !== 1'b1; i++) tick(1);
    while (delay_run === 1'b1) begin
      n++;
      tick(1);
      if (n > 20000) begin
        mismatches++;
        results();
      end
    end
    chk(nm, 24'(e), 24'(n));
    tick(2);
  endtask : dly

  initial begin
    tick(5);
    resetn = 1'b1;
    supply_ok = 1'b1;
    tick(8);
    chk("standby", 1, standby);
    chk("deep_sleep", 0, deep_sleep);
    chk("latch", 0, latch);
    chk("factory", 0, factory);
    send(1, {OPC_RELEASE, 48'h0});
    dly("release_standby", 0);
    cmd(OPC_DEEP_SLEEP);
    chk("deep_sleep", 1, deep_sleep);
    cmd(OPC_WRITE_UNLOCK);
    chk("sleep_latch", 0, latch);
    send(1, {OPC_RELEASE, 48'h0});
    dly("release_deep", REL);
    chk("standby", 1, standby);
    chk("deep_sleep", 0, deep_sleep);
    $display("test release done");
    for (int s = 0; s < 2; s++) begin
      if (s == 1) cmd(OPC_DEEP_SLEEP);
      send(7, {OPC_SIG_READ, 48'h0});
      chk("signature", {8'h0, SIGNATURE, SIGNATURE}, {8'h0, rx});
      dly("sig_release", s ? SREL : 0);
    end
    $display("test signature done");
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 7 : $unsigned($random(seed)) % 10;
      send(7, {OPC_PTBL_READ, 24'(a), 24'h0});
      chk("ptbl", {8'h0, tbl_exp(a), tbl_exp(a + 1)}, {8'h0, rx});
      tick(10);
      chk("so_oe", 0, so_oe);
    end
    $display("test table done");
    cmd(OPC_WRITE_UNLOCK);
    cmd(OPC_RESET_ARM);
    cmd(OPC_FACTORY);
    cmd(OPC_RESET);
    chk("latch_kept", 1, latch);
    chk("factory_kept", 1, factory);
    cmd(OPC_RESET_ARM);
    send(1, {OPC_RESET, 48'h0});
    dly("recovery_other", ROTH);
    chk("latch", 0, latch);
    chk("factory", 0, factory);
    array_busy = 1'b1;
    array_prog = 1'b1;
    b_abt = n_abt;
    cmd(OPC_RESET_ARM);
    send(1, {OPC_RESET, 48'h0});
    dly("recovery_prog", RPRG);
    chk("abort", 1, 24'(n_abt - b_abt));
    array_prog = 1'b0;
    b_oe = n_oe;
    b_abt = n_abt;
    send(7, {OPC_SIG_READ, 48'h0});
    tick(10);
    chk("busy_sig_oe", 0, 24'(n_oe - b_oe));
    chk("busy_abort", 0, 24'(n_abt - b_abt));
    array_busy = 1'b0;
    cmd(OPC_DEEP_SLEEP);
    array_busy = 1'b1;
    send(1, {OPC_RELEASE, 48'h0});
    tick(10);
    chk("busy_release", 1, deep_sleep);
    chk("busy_release_run", 0, delay_run);
    array_busy = 1'b0;
    send(1, {OPC_RELEASE, 48'h0});
    dly("release_idle", REL);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      ea = 24'($random(seed));
      cmd(OPC_WRITE_UNLOCK);
      cmd(OPC_FACTORY);
      b_ers = n_ers;
      if (k == 3) send(1, {OPC_CHIP_ERASE, 48'h0});
      else send(4, {OPC_SECTOR_ERASE + 8'(k), ea, 24'h0});
      tick(10);
      chk("erase_count", 1, 24'(n_ers - b_ers));
      chk("erase_kind", 24'(k), 24'(erase_kind));
      if (k < 3) chk("erase_addr", ea, erase_addr);
      chk("factory_set", 1, factory);
      array_busy = 1'b1;
      tick(5);
      array_busy = 1'b0;
      tick(3);
      chk("factory_done", 0, factory);
      chk("latch_done", 0, latch);
    end
    $display("test erase done");
    supply_ok = 1'b0;
    tick(6);
    cmd(OPC_WRITE_UNLOCK);
    chk("low_supply", 0, latch);
    supply_ok = 1'b1;
    tick(8);
    cmd(OPC_WRITE_UNLOCK);
    chk("supply_back", 1, latch);
    $display("test supply done");
    results();
  end
endmodule : tb
